// ---- core/scd_card_status.sv ----
// scd_card_status: card-present watcher, radio lamp and host wake output
// assumes card_present_in is synchronous-safe via the local two-stage sync
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - default polarity: high means card inserted
// - hot-plug on after reset, continuous monitoring
// - hot-plug off: sample once at start-up; the boot sample reads the sync reset value, so it always decides detached
// - inserted: read card, initialise, register
// - detached: card absent, no read accesses
// - polarity setting inverts inserted/detached meaning
// - lamp low while radio on
// - wake low one second per event
module scd_card_status #(
    parameter int unsigned WAKE_CYC = scd_pkg::WAKE_PULSE_CYC
) (
    input wire logic clock, // 200 MHz system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic card_present_in, // slot detect switch
    input wire logic [3:0] regAddr, // register word address
    input wire logic [31:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [31:0] regRdata, // read data, cycle after strobe
    input wire logic cardReadDone, // card information read finished
    input wire logic initDone, // initialisation and registration done
    output logic cardReadReq, // card read accesses allowed
    output logic cardInitReq, // run initialisation sequence
    output logic cardReady, // card registered
    output logic radio_status_lamp_n, // lamp, low is lit
    output logic host_wake_n, // host wake, low pulse
    output logic irq // level interrupt
);
    import scd_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic presPrev;
        logic hotPlug;
        logic actLow;
        logic radioOn;
        logic [1:0] irqStat;
        logic [1:0] irqMask;
        logic [31:0] rdata;
        scd_state_e state;
        logic present;
    } scd_top_s;

    scd_top_s st;
    scd_top_s next_st;
    logic presNow;
    logic wakeTrig;
    logic evInsert;
    logic evDetach;
    logic wakeN;

    // ==========================================================
    // polarity and edge detection on the second sync stage
    assign presNow = st.sync2 ^ st.actLow;
    assign evInsert = st.hotPlug && st.state != SCD_BOOT
        && presNow && !st.presPrev;
    assign evDetach = st.hotPlug && st.state != SCD_BOOT
        && !presNow && st.presPrev;
    assign wakeTrig = regWr && regAddr == REG_EVENT
        && (regWdata[EV_RING] || regWdata[EV_SMS] || regWdata[EV_DATA]);

    // ==========================================================
    // next-state logic
    always_comb begin
        next_st = st;
        next_st.sync1 = card_present_in;
        next_st.sync2 = st.sync1;
        next_st.presPrev = presNow;
        next_st.rdata = 32'h0;

        // register writes
        if (regWr) begin
            unique case (regAddr)
                REG_CTRL: begin
                    next_st.hotPlug = regWdata[CTRL_HOTPLUG];
                    next_st.actLow = regWdata[CTRL_ACTLOW];
                    next_st.radioOn = regWdata[CTRL_RADIO];
                end
                REG_IRQ_MASK: begin
                    next_st.irqMask = regWdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // register reads; interrupt status read clears, set wins below
        if (regRd) begin
            unique case (regAddr)
                REG_CTRL: begin
                    next_st.rdata = {29'h0, st.radioOn, st.actLow,
                        st.hotPlug};
                end
                REG_STATUS: begin
                    next_st.rdata = {24'h0, 3'h0, st.state};
                    next_st.rdata[5] = st.present;
                    next_st.rdata[6] = presNow;
                end
                REG_IRQ_STAT: begin
                    next_st.rdata = {30'h0, st.irqStat};
                    next_st.irqStat = 2'h0;
                end
                REG_IRQ_MASK: begin
                    next_st.rdata = {30'h0, st.irqMask};
                end
                default: begin
                    next_st.rdata = 32'h0;
                end
            endcase
        end
        if (evInsert) begin
            next_st.irqStat[IRQ_INSERT] = 1'b1;
        end
        if (evDetach) begin
            next_st.irqStat[IRQ_DETACH] = 1'b1;
        end

        // card handling sequence
        unique case (st.state)
            SCD_BOOT: begin
                // first decision on the clock after reset, from the reset value of the sync stage: the one-time read
                next_st.present = presNow;
                next_st.state = presNow ? SCD_READ : SCD_ABSENT;
            end
            SCD_ABSENT: begin
                next_st.present = 1'b0;
                if (st.hotPlug && presNow) begin
                    next_st.present = 1'b1;
                    next_st.state = SCD_READ;
                end
            end
            SCD_READ: begin
                if (st.hotPlug && !presNow) begin
                    next_st.state = SCD_ABSENT;
                end else if (cardReadDone) begin
                    next_st.state = SCD_INIT;
                end
            end
            SCD_INIT: begin
                if (st.hotPlug && !presNow) begin
                    next_st.state = SCD_ABSENT;
                end else if (initDone) begin
                    next_st.state = SCD_READY;
                end
            end
            SCD_READY: begin
                // with hot-plug off later changes are ignored
                if (st.hotPlug && !presNow) begin
                    next_st.state = SCD_ABSENT;
                end
            end
            default: begin
                next_st.state = SCD_BOOT;
            end
        endcase
    end

    // state register; reset enters boot, which decides on the next clock without waiting for the sync to fill
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st.sync1 <= 1'b0;
            st.sync2 <= 1'b0;
            st.presPrev <= 1'b0;
            st.hotPlug <= 1'b1;
            st.actLow <= 1'b0;
            st.radioOn <= 1'b0;
            st.irqStat <= IRQ_RESET;
            st.irqMask <= 2'h0;
            st.rdata <= 32'h0;
            st.state <= SCD_BOOT;
            st.present <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // host wake pulse stretcher
    scd_wake_pulse #(
        .PULSE_CYC(WAKE_CYC)
    ) uWake (
        .clock(clock),
        .rst_n(rst_n),
        .trigger(wakeTrig),
        .wake_n(wakeN)
    );

    // ==========================================================
    // outputs
    assign regRdata = st.rdata;
    assign cardReadReq = st.state == SCD_READ;
    assign cardInitReq = st.state == SCD_INIT;
    assign cardReady = st.state == SCD_READY;
    assign radio_status_lamp_n = ~st.radioOn;
    assign host_wake_n = wakeN;
    assign irq = |(st.irqStat & st.irqMask);
endmodule
`default_nettype wire

// ---- core/scd_pkg.sv ----
// scd_pkg: constants and types shared by the card-detect and status block
// assumes a 200 MHz system clock and a plain register port
package scd_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned WAKE_PULSE_MS = 1000;
    localparam int unsigned WAKE_PULSE_CYC = (CLK_HZ / 1000) * WAKE_PULSE_MS;

    // ==========================================================
    // register map (word offsets on the register port)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam logic [3:0] REG_EVENT = 4'h4;

    // control fields
    localparam int CTRL_HOTPLUG = 0;
    localparam int CTRL_ACTLOW = 1;
    localparam int CTRL_RADIO = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;

    // event-trigger fields (write-one pulses)
    localparam int EV_RING = 0;
    localparam int EV_SMS = 1;
    localparam int EV_DATA = 2;

    // interrupt status fields
    localparam int IRQ_INSERT = 0;
    localparam int IRQ_DETACH = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // card handling states
    typedef enum logic [4:0] {
        SCD_BOOT = 5'h01,
        SCD_ABSENT = 5'h02,
        SCD_READ = 5'h04,
        SCD_INIT = 5'h08,
        SCD_READY = 5'h10
    } scd_state_e;

endpackage

// ---- core/scd_wake_pulse.sv ----
// scd_wake_pulse: stretches a trigger into a low pulse of fixed length
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module scd_wake_pulse #(
    parameter int unsigned PULSE_CYC = scd_pkg::WAKE_PULSE_CYC
) (
    input wire logic clock, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic trigger, // one-cycle wake request
    output logic wake_n // low while the pulse runs
);
    import scd_pkg::*;

    typedef struct packed {
        logic [31:0] count;
        logic low;
    } scd_wp_s;

    scd_wp_s st;
    scd_wp_s next_st;

    // ==========================================================
    // pulse timer: a new trigger restarts the full length
    always_comb begin
        next_st = st;
        if (trigger) begin
            next_st.low = 1'b1;
            next_st.count = 32'(PULSE_CYC - 1);
        end else if (st.low) begin
            if (st.count == 32'h0) begin
                next_st.low = 1'b0;
            end else begin
                next_st.count = st.count - 32'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wake_n = ~st.low; // held high when idle
endmodule
`default_nettype wire

// ---- tb/scd_card_status_sva.sv ----
// port checker for scd_card_status
// assumes wake length 8 and spaced CTRL writes
`timescale 1ns/1ps
`default_nettype none
module scd_card_status_sva
    import scd_pkg::*;
(
    input wire logic clock, // clock
    input wire logic rst_n, // reset
    input wire logic [3:0] regAddr, // addr
    input wire logic [31:0] regWdata, // wdata
    input wire logic regWr, // write
    input wire logic regRd, // read
    input wire logic [31:0] regRdata, // rdata
    input wire logic cardReadDone, // read done
    input wire logic initDone, // init done
    input wire logic cardReadReq, // reading
    input wire logic cardInitReq, // initialising
    input wire logic cardReady, // ready
    input wire logic radio_status_lamp_n, // lamp
    input wire logic host_wake_n, // wake
    input wire logic irq // irq
);
    // ====
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    lamp_ctrl_a: assert property (regWr && regAddr == REG_CTRL |=> ##2
        radio_status_lamp_n == !$past(regWdata[CTRL_RADIO], 3))
        else $error("lamp wrong");
    wake_start_a: assert property (regWr && regAddr == REG_EVENT
        && |regWdata[2:0] |=> !host_wake_n) else $error("no wake");
    wake_len_a: assert property ($fell(host_wake_n) |->
        (!host_wake_n)[*8] ##1 host_wake_n) else $error("wake length");
    rd_idle_a: assert property (!regRd |=> regRdata == 32'h0)
        else $error("stray rdata");
    state_one_a: assert property ($onehot0({cardReadReq, cardInitReq,
        cardReady})) else $error("states overlap");
    read_init_a: assert property (cardReadReq && cardReadDone
        |=> cardInitReq) else $error("no init");
    init_ready_a: assert property (cardInitReq && initDone
        |=> cardReady) else $error("no ready");
    reset_val_a: assert property (disable iff (1'b0) !rst_n |=>
        host_wake_n && radio_status_lamp_n && !irq && !cardReadReq)
        else $error("reset values");
endmodule
`default_nettype wire

// ---- tb/scd_card_status_tb_top.sv ----
// bench for scd_card_status with slot model
// assumes wake pulse shortened to 8 cycles
`timescale 1ns/1ps
`default_nettype none
module scd_card_status_tb_top;
    import scd_pkg::*;
    // ====
    logic clock = 0, rst_n = 0, regWr = 0, regRd = 0, cardIn = 0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic cpIn, rdDone, inDone, rdReq, inReq, rdy, lampN, wakeN, irq;
    int errorCnt = 0, nTests = 0, n;
    always #2.5 clock = ~clock;
    scd_slot_model scd_slot_model_i (.clock(clock), .cardIn(cardIn),
        .cardReadReq(rdReq), .cardInitReq(inReq), .card_present_in(cpIn),
        .cardReadDone(rdDone), .initDone(inDone));
    scd_card_status #(.WAKE_CYC(8)) scd_card_status_i (.clock(clock),
        .rst_n(rst_n), .card_present_in(cpIn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .cardReadDone(rdDone), .initDone(inDone),
        .cardReadReq(rdReq), .cardInitReq(inReq), .cardReady(rdy),
        .radio_status_lamp_n(lampN), .host_wake_n(wakeN), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regWr <= 1; regAddr <= a; regWdata <= d;
        @(posedge clock); regWr <= 0; @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        regRd <= 1; regAddr <= a;
        @(posedge clock); regRd <= 0; #1 chk(regRdata, exp);
        @(posedge clock);
    endtask
    task automatic gap(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    task automatic endSim;
        if (errorCnt == 0 && nTests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // card insert, read, init and detach with interrupts
    task automatic t_card;
        rd(REG_CTRL, 32'h1);
        rd(REG_STATUS, 32'h2);
        cardIn <= 1; gap(12);
        chk(rdy, 1);
        chk(irq, 0);
        rd(REG_IRQ_STAT, 32'h1);
        wr(REG_IRQ_MASK, 32'h3);
        cardIn <= 0; gap(5);
        chk(irq, 1);
        rd(REG_STATUS, 32'h2);
        chk(rdReq, 0);
        rd(REG_IRQ_STAT, 32'h2);
        gap(1); chk(irq, 0);
    endtask
    // polarity flip, then hot-plug off
    task automatic t_mode;
        wr(REG_CTRL, 32'h3); gap(12);
        rd(REG_STATUS, 32'h70);
        wr(REG_CTRL, 32'h1); gap(5);
        rd(REG_IRQ_STAT, 32'h3);
        wr(REG_CTRL, 32'h0); cardIn <= 1; gap(10);
        rd(REG_STATUS, 32'h42);
        cardIn <= 0; gap(3);
        wr(REG_CTRL, 32'h5); gap(3);
        chk(lampN, 0);
        wr(REG_CTRL, 32'h1); gap(3);
        chk(lampN, 1);
        rd(4'hf, 32'h0);
    endtask
    // each wake event gives one 8 cycle pulse
    task automatic t_wake;
        for (int b = 0; b < 3; b++) begin
            regWr <= 1; regAddr <= REG_EVENT; regWdata <= 32'h1 << b;
            @(posedge clock); regWr <= 0; #1;
            for (n = 0; wakeN === 0 && n < 50; n++) gap(1);
            chk(n, 8);
            gap(2);
        end
    endtask
    // main sequence
    initial begin
        gap(2); rst_n <= 1; @(posedge clock);
        t_card; t_mode; t_wake;
        endSim;
    end
    // watchdog
    initial begin
        gap(3000); errorCnt++; endSim;
    end
endmodule
bind scd_card_status scd_card_status_sva scd_card_status_sva_i (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .cardReadDone(cardReadDone), .initDone(initDone),
    .cardReadReq(cardReadReq), .cardInitReq(cardInitReq),
    .cardReady(cardReady), .radio_status_lamp_n(radio_status_lamp_n),
    .host_wake_n(host_wake_n), .irq(irq));
`default_nettype wire

// ---- tb/scd_slot_model.sv ----
// slot switch and host side model
// assumes the bench sets cardIn
`timescale 1ns/1ps
`default_nettype none
module scd_slot_model #(
    parameter int DLY = 3
) (
    input wire logic clock, // clock
    input wire logic cardIn, // card in slot
    input wire logic cardReadReq, // read req
    input wire logic cardInitReq, // init req
    output logic card_present_in, // switch
    output logic cardReadDone, // read done
    output logic initDone // init done
);
    // ====
    int cnt;
    // switch is high with a card inside
    assign card_present_in = cardIn;
    // answer a request after DLY cycles; restart the count per phase
    always_ff @(posedge clock) begin
        cnt <= ((cardReadReq || cardInitReq)
            && !(cardReadDone || initDone)) ? cnt + 1 : 0;
    end
    assign cardReadDone = cardReadReq && cnt >= DLY;
    assign initDone = cardInitReq && cnt >= DLY;
endmodule
`default_nettype wire
